// [nalu_core.sv]
// How it works
// - add sums register+memory into register, or memory+immediate into memory
// - add with carry adds carry flag too, same destinations as add
// - subtract takes memory from register, or immediate from memory
// - subtract with borrow also subtracts carry flag, same destinations
// - or combines register with memory, or memory with immediate
// - and combines operands bitwise in the same two forms
// - exclusive-or combines operands bitwise in the same two forms
// - bits-true test clears compare flag, skips when all masked bits are one
// - bits-false test clears compare flag, skips when all masked bits are zero
// - equal and unequal tests subtract immediate, skip on zero or nonzero
// - magnitude tests subtract immediate, skip on no borrow or borrow
// - rotate shifts general register right through carry, result to register
// - status flags and flag word at 7eh and 7fh are the same storage
// - binary works on four bits, decimal on one digit via correction stage
// - every operation completes in one request cycle
// - zero flag set on an arithmetic 0000b; with compare flag a zero result holds it
// - compare flag set blocks arithmetic result writes only
// - decimal flag corrects arithmetic only
// - rotate puts old carry into bit 3 and old bit 0 into carry
`timescale 1ns/1ns
`default_nettype none
module nalu_core
#(
  parameter int ADDR_W = nalu_pkg::NALU_ADDR_W,
  parameter int DATA_W = nalu_pkg::NALU_DATA_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire nalu_pkg::nalu_req_type op_req,
  output nalu_pkg::nalu_res_type res_reg,
  output logic res_valid_reg,
  output nalu_pkg::nalu_flags_type flags_reg,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [DATA_W-1:0] bus_rdata_reg
);

  // true for the four arithmetic operations
  function automatic logic is_arith(input nalu_pkg::nalu_op_type op);
    is_arith = (op == nalu_pkg::op_add) || (op == nalu_pkg::add_with_carry_op) ||
      (op == nalu_pkg::op_sub) || (op == nalu_pkg::subtract_with_borrow_op);
  endfunction

  // true for operations that subtract, comparisons included
  function automatic logic is_subtract(input nalu_pkg::nalu_op_type op);
    is_subtract = (op == nalu_pkg::op_sub) || (op == nalu_pkg::subtract_with_borrow_op) ||
      (op == nalu_pkg::skip_if_equal_op) || (op == nalu_pkg::skip_if_unequal_op) ||
      (op == nalu_pkg::skip_if_not_below_op) || (op == nalu_pkg::skip_if_below_op);
  endfunction

  // true for the four comparison tests
  function automatic logic is_compare(input nalu_pkg::nalu_op_type op);
    is_compare = (op == nalu_pkg::skip_if_equal_op) || (op == nalu_pkg::skip_if_unequal_op) ||
      (op == nalu_pkg::skip_if_not_below_op) || (op == nalu_pkg::skip_if_below_op);
  endfunction

  logic [3:0] opnd_a;
  logic [3:0] opnd_b;
  logic use_carry;
  logic do_sub;
  logic [3:0] bin_sum;
  logic bin_cout;
  logic [3:0] dec_sum;
  logic dec_cout;
  logic [3:0] arith_res;
  logic arith_cout;
  logic [3:0] cmp_diff;
  logic cmp_borrow;
  logic [3:0] logic_res;
  logic [3:0] mask_hits;
  nalu_pkg::nalu_res_type res_next;
  nalu_pkg::nalu_flags_type flags_next;
  nalu_pkg::nalu_flags_type flags_bus;
  logic [3:0] last_result_reg;
  logic [DATA_W-1:0] rdata_next;

  // operand steering: register form keeps the register as minuend;
  // comparisons always weigh memory against immediate, whatever the form
  always_comb
  begin
    if (op_req.form == nalu_pkg::form_reg_mem && !is_compare(op_req.op))
    begin
      opnd_a = op_req.gen_reg;
      opnd_b = op_req.mem_data;
    end
    else
    begin
      opnd_a = op_req.mem_data;
      opnd_b = op_req.imm;
    end
  end

  assign use_carry = (op_req.op == nalu_pkg::add_with_carry_op) ||
    (op_req.op == nalu_pkg::subtract_with_borrow_op);
  assign do_sub = is_subtract(op_req.op);

  nalu_adder u_adder
  (
    .a(opnd_a),
    .b(opnd_b),
    .cin(use_carry & flags_reg.carry_flag),
    .sub(do_sub),
    .sum(bin_sum),
    .cout(bin_cout)
  );

  nalu_bcd_adjust u_bcd
  (
    .bin_sum(bin_sum),
    .bin_cout(bin_cout),
    .sub(do_sub),
    .dec_sum(dec_sum),
    .dec_cout(dec_cout)
  );

  always_comb
  begin
    if (flags_reg.decimal_flag)
    begin
      arith_res = dec_sum;
      arith_cout = dec_cout;
    end
    else
    begin
      arith_res = bin_sum;
      arith_cout = bin_cout;
    end
  end

  // comparisons never see decimal correction; carry-in is forced off for them
  assign cmp_diff = bin_sum;
  assign cmp_borrow = bin_cout;

  always_comb
  begin
    logic_res = opnd_a ^ opnd_b;
    if (op_req.op == nalu_pkg::op_or)
      logic_res = opnd_a | opnd_b;
    else if (op_req.op == nalu_pkg::op_and)
      logic_res = opnd_a & opnd_b;
  end

  // bit tests look at the memory nibble through the immediate mask
  assign mask_hits = op_req.mem_data & op_req.imm;

  // result and write strobes; one request, one answer, no stall
  always_comb
  begin
    res_next = '0;
    unique case (op_req.op)
      nalu_pkg::op_add,
      nalu_pkg::add_with_carry_op,
      nalu_pkg::op_sub,
      nalu_pkg::subtract_with_borrow_op:
      begin
        res_next.data = arith_res;
        res_next.wr_reg = !flags_reg.compare_hold_flag &&
          (op_req.form == nalu_pkg::form_reg_mem);
        res_next.wr_mem = !flags_reg.compare_hold_flag &&
          (op_req.form == nalu_pkg::form_mem_imm);
      end
      nalu_pkg::op_or,
      nalu_pkg::op_and,
      nalu_pkg::op_xor:
      begin
        res_next.data = logic_res;
        res_next.wr_reg = (op_req.form == nalu_pkg::form_reg_mem);
        res_next.wr_mem = (op_req.form == nalu_pkg::form_mem_imm);
      end
      nalu_pkg::skip_if_bits_true_op:
        res_next.skip = (mask_hits == op_req.imm);
      nalu_pkg::skip_if_bits_false_op:
        res_next.skip = (mask_hits == 4'h0);
      nalu_pkg::skip_if_equal_op:
        res_next.skip = (cmp_diff == 4'h0);
      nalu_pkg::skip_if_unequal_op:
        res_next.skip = (cmp_diff != 4'h0);
      nalu_pkg::skip_if_not_below_op:
        res_next.skip = !cmp_borrow;
      nalu_pkg::skip_if_below_op:
        res_next.skip = cmp_borrow;
      nalu_pkg::rotate_right_through_carry_op:
      begin
        res_next.data = {flags_reg.carry_flag, op_req.gen_reg[3:1]};
        res_next.wr_reg = 1'b1;
      end
      default:
      begin
        // unused opcodes answer with no write and no skip
        res_next = '0;
      end
    endcase
  end

  always_comb
  begin
    flags_bus = flags_reg;
    if (bus_write && bus_addr == ADDR_W'(nalu_pkg::NALU_FLAG_MODE_ADDR))
      flags_bus.decimal_flag = bus_wdata[nalu_pkg::NALU_DECIMAL_BIT];
    if (bus_write && bus_addr == ADDR_W'(nalu_pkg::NALU_FLAG_STAT_ADDR))
    begin
      flags_bus.compare_hold_flag = bus_wdata[nalu_pkg::NALU_COMPARE_BIT];
      flags_bus.carry_flag = bus_wdata[nalu_pkg::NALU_CARRY_BIT];
      flags_bus.zero_flag = bus_wdata[nalu_pkg::NALU_ZERO_BIT];
    end
  end

  // an operation's own flag update wins over a word write in the same cycle,
  // so a hardware event is never lost; untouched flags take the write
  always_comb
  begin
    flags_next = flags_bus;
    if (op_valid)
    begin
      if (is_arith(op_req.op))
      begin
        flags_next.carry_flag = arith_cout;
        if (arith_res != 4'h0)
          flags_next.zero_flag = 1'b0;
        else if (!flags_reg.compare_hold_flag)
          flags_next.zero_flag = 1'b1;
        else
          flags_next.zero_flag = flags_reg.zero_flag;
      end
      else if (op_req.op == nalu_pkg::skip_if_bits_true_op ||
        op_req.op == nalu_pkg::skip_if_bits_false_op)
      begin
        flags_next.compare_hold_flag = 1'b0;
      end
      else if (op_req.op == nalu_pkg::rotate_right_through_carry_op)
      begin
        flags_next.carry_flag = op_req.gen_reg[0];
      end
      else if (is_compare(op_req.op))
      begin
        flags_next = flags_bus;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_reg.decimal_flag <= nalu_pkg::NALU_FLAG_RST;
      flags_reg.compare_hold_flag <= nalu_pkg::NALU_FLAG_RST;
      flags_reg.carry_flag <= nalu_pkg::NALU_FLAG_RST;
      flags_reg.zero_flag <= nalu_pkg::NALU_FLAG_RST;
    end
    else
      flags_reg <= flags_next;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      res_reg <= '0;
      res_valid_reg <= 1'b0;
    end
    else
    begin
      res_valid_reg <= op_valid;
      if (op_valid)
        res_reg <= res_next;
      else
        res_reg <= '0;
    end
  end

  // last value that an operation wrote to register or memory, kept for software to inspect
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      last_result_reg <= nalu_pkg::NALU_NIBBLE_RST;
    else if (op_valid && (res_next.wr_reg || res_next.wr_mem))
      last_result_reg <= res_next.data;
  end

  // read mux; the data register reflects the flags as of the read cycle
  always_comb
  begin
    rdata_next = '0;
    if (bus_addr == ADDR_W'(nalu_pkg::NALU_FLAG_MODE_ADDR))
      rdata_next[nalu_pkg::NALU_DECIMAL_BIT] = flags_reg.decimal_flag;
    else if (bus_addr == ADDR_W'(nalu_pkg::NALU_FLAG_STAT_ADDR))
    begin
      rdata_next[nalu_pkg::NALU_COMPARE_BIT] = flags_reg.compare_hold_flag;
      rdata_next[nalu_pkg::NALU_CARRY_BIT] = flags_reg.carry_flag;
      rdata_next[nalu_pkg::NALU_ZERO_BIT] = flags_reg.zero_flag;
    end
    else if (bus_addr == ADDR_W'(nalu_pkg::NALU_LAST_RESULT_ADDR))
      rdata_next = DATA_W'(last_result_reg);
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bus_rdata_reg <= '0;
    else if (bus_read)
      bus_rdata_reg <= rdata_next;
    else
      bus_rdata_reg <= '0;
  end

endmodule
`default_nettype wire

// [nalu_pkg.sv]
package nalu_pkg;

  // register map, nibble wide data
  localparam int NALU_ADDR_W = 8;
  localparam int NALU_DATA_W = 4;
  localparam logic [7:0] NALU_FLAG_MODE_ADDR = 8'h7e;
  localparam logic [7:0] NALU_FLAG_STAT_ADDR = 8'h7f;
  localparam logic [7:0] NALU_LAST_RESULT_ADDR = 8'h7d;

  // field positions inside the two flag nibbles
  localparam int NALU_DECIMAL_BIT = 0;
  localparam int NALU_ZERO_BIT = 0;
  localparam int NALU_CARRY_BIT = 1;
  localparam int NALU_COMPARE_BIT = 2;

  // reset values and decimal correction constants
  localparam logic NALU_FLAG_RST = 1'h0;
  localparam logic [3:0] NALU_NIBBLE_RST = 4'h0;
  localparam logic [3:0] NALU_BCD_LIMIT = 4'h9;
  localparam logic [3:0] NALU_BCD_ADJUST = 4'h6;

  // operation codes seen from the instruction decoder
  typedef enum logic [3:0] {
    op_add = 4'h0,
    add_with_carry_op = 4'h1,
    op_sub = 4'h2,
    subtract_with_borrow_op = 4'h3,
    op_or = 4'h4,
    op_and = 4'h5,
    op_xor = 4'h6,
    skip_if_bits_true_op = 4'h7,
    skip_if_bits_false_op = 4'h8,
    skip_if_equal_op = 4'h9,
    skip_if_unequal_op = 4'ha,
    skip_if_not_below_op = 4'hb,
    skip_if_below_op = 4'hc,
    rotate_right_through_carry_op = 4'hd
  } nalu_op_type;

  // operand form: register with memory, or memory with immediate
  typedef enum logic {
    form_reg_mem = 1'b0,
    form_mem_imm = 1'b1
  } nalu_form_type;

  typedef struct packed {
    nalu_op_type op;
    nalu_form_type form;
    logic [3:0] gen_reg;
    logic [3:0] mem_data;
    logic [3:0] imm;
  } nalu_req_type;

  typedef struct packed {
    logic [3:0] data;
    logic wr_reg;
    logic wr_mem;
    logic skip;
  } nalu_res_type;

  typedef struct packed {
    logic decimal_flag;
    logic compare_hold_flag;
    logic carry_flag;
    logic zero_flag;
  } nalu_flags_type;

endpackage

// [nalu_adder.sv]
`timescale 1ns/1ns
`default_nettype none
// four-bit add or subtract with carry/borrow in and out
module nalu_adder
(
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic cin,
  input wire logic sub,
  output logic [3:0] sum,
  output logic cout
);

  logic [4:0] wide;

  // borrow shows as bit 4 of the five-bit difference
  always_comb
  begin
    if (sub)
      wide = {1'b0, a} - {1'b0, b} - {4'h0, cin};
    else
      wide = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    sum = wide[3:0];
    cout = wide[4];
  end

endmodule
`default_nettype wire

// [nalu_bcd_adjust.sv]
`timescale 1ns/1ns
`default_nettype none
// decimal correction of one binary digit result
module nalu_bcd_adjust
(
  input wire logic [3:0] bin_sum,
  input wire logic bin_cout,
  input wire logic sub,
  output logic [3:0] dec_sum,
  output logic dec_cout
);

  // addition: ten or more adds six; subtraction: a borrow removes six
  // digits above nine on input are not checked and can give a result of 0ah or more, by design
  always_comb
  begin
    dec_sum = bin_sum;
    dec_cout = bin_cout;
    if (!sub && (bin_cout || bin_sum > nalu_pkg::NALU_BCD_LIMIT))
    begin
      dec_sum = bin_sum + nalu_pkg::NALU_BCD_ADJUST;
      dec_cout = 1'b1;
    end
    else if (sub && bin_cout)
    begin
      dec_sum = bin_sum - nalu_pkg::NALU_BCD_ADJUST;
    end
  end

endmodule
`default_nettype wire

// [nalu_core_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the nibble alu core
module nalu_core_assertions
#(
  parameter int ADDR_W = nalu_pkg::NALU_ADDR_W,
  parameter int DATA_W = nalu_pkg::NALU_DATA_W
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire nalu_pkg::nalu_req_type op_req,
  input wire nalu_pkg::nalu_res_type res_reg,
  input wire logic res_valid_reg,
  input wire nalu_pkg::nalu_flags_type flags_reg,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  input wire logic [DATA_W-1:0] bus_rdata_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_ans;
    op_valid |=> res_valid_reg;
  endproperty
  a_ans: assert property (p_ans)
    else $error("no answer after request");

  property p_idle;
    !op_valid |=> !res_valid_reg && res_reg == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");

  // logic and comparisons must not disturb any flag
  property p_hold;
    op_valid && !bus_write && (op_req.op inside {[4'h4:4'h6], [4'h9:4'hc]})
      |=> $stable(flags_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flags moved on logic or compare");

  property p_nowr;
    op_valid && op_req.op <= 4'h3 && flags_reg.compare_hold_flag
      |=> !res_reg.wr_reg && !res_reg.wr_mem;
  endproperty
  a_nowr: assert property (p_nowr)
    else $error("arithmetic stored under compare hold");

  property p_zero;
    op_valid && op_req.op <= 4'h3 && !flags_reg.compare_hold_flag
      |=> flags_reg.zero_flag == (res_reg.data == 4'h0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with result");

  property p_bit;
    op_valid && (op_req.op inside {4'h7, 4'h8}) |=> !flags_reg.compare_hold_flag;
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit test left compare hold set");

  property p_rot;
    op_valid && op_req.op == nalu_pkg::rotate_right_through_carry_op
      |=> res_reg.wr_reg && flags_reg.carry_flag == $past(op_req.gen_reg[0])
      && res_reg.data == {$past(flags_reg.carry_flag), $past(op_req.gen_reg[3:1])};
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotate result or carry wrong");

  property p_eq;
    op_valid && op_req.op == nalu_pkg::skip_if_equal_op
      |=> res_reg.skip == ($past(op_req.mem_data) == $past(op_req.imm));
  endproperty
  a_eq: assert property (p_eq)
    else $error("equal skip wrong");

  property p_lt;
    op_valid && op_req.op == nalu_pkg::skip_if_below_op
      |=> res_reg.skip == ($past(op_req.mem_data) < $past(op_req.imm));
  endproperty
  a_lt: assert property (p_lt)
    else $error("below skip wrong");

  property p_rd;
    bus_read && !op_valid && bus_addr == nalu_pkg::NALU_FLAG_STAT_ADDR
      |=> bus_rdata_reg == {1'b0, $past(flags_reg[2:0])};
  endproperty
  a_rd: assert property (p_rd)
    else $error("flag word read differs from flags");

  property p_wr;
    bus_write && !op_valid && bus_addr == nalu_pkg::NALU_FLAG_MODE_ADDR
      |=> flags_reg.decimal_flag == $past(bus_wdata[0]);
  endproperty
  a_wr: assert property (p_wr)
    else $error("flag word write missed decimal flag");
endmodule

bind nalu_core nalu_core_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_req(op_req),
  .res_reg(res_reg), .res_valid_reg(res_valid_reg), .flags_reg(flags_reg),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
  .bus_read(bus_read), .bus_rdata_reg(bus_rdata_reg));
`default_nettype wire

// [nalu_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
// general register and one memory nibble on the decoder side;
// only a strobed nibble moves, so a stray write shows at once
module nalu_mem_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire nalu_pkg::nalu_res_type res,
  output logic [3:0] gen_nib_reg,
  output logic [3:0] mem_nib_reg
);
  // store results where the strobes point
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gen_nib_reg <= 4'h0;
      mem_nib_reg <= 4'h0;
    end
    else
    begin
      if (res.wr_reg)
        gen_nib_reg <= res.data;
      if (res.wr_mem)
        mem_nib_reg <= res.data;
    end
  end
endmodule
`default_nettype wire

// [nibble_alu_with_bcd_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module nibble_alu_with_bcd_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  nalu_pkg::nalu_req_type op_req = '0;
  nalu_pkg::nalu_res_type res_reg;
  logic res_valid_reg;
  nalu_pkg::nalu_flags_type flags_reg;
  logic [7:0] bus_addr = 8'h00;
  logic [3:0] bus_wdata = 4'h0;
  logic bus_write = 1'b0;
  logic bus_read = 1'b0;
  logic [3:0] bus_rdata_reg;
  logic [3:0] gen_nib;
  logic [3:0] mem_nib;
  int miscompares = 0;
  int samples_checked = 0;
  logic [35:0] r;
  // nibbles: op form gen mem imm flags_in data {0,wr_reg,wr_mem,skip} flags_out
  logic [35:0] rows [36] = '{
    36'h0_0_3_4_0_0_7_4_0, 36'h0_1_0_9_7_0_0_2_3, 36'h1_0_2_5_0_2_8_4_0,
    36'h1_1_0_e_0_2_f_2_0, 36'h2_0_3_5_0_0_e_4_2, 36'h2_1_0_8_8_0_0_2_1,
    36'h3_0_5_2_0_2_2_4_0, 36'h3_1_0_0_0_2_f_2_2, 36'h4_0_a_5_0_f_f_4_f,
    36'h4_1_0_1_2_0_3_2_0, 36'h5_0_c_a_0_0_8_4_0, 36'h5_1_0_f_3_5_3_2_5,
    36'h6_0_f_5_0_0_a_4_0, 36'h6_1_0_3_3_a_0_2_a, 36'h7_1_0_b_3_e_0_1_a,
    36'h7_1_0_8_3_4_0_0_0, 36'h8_1_0_8_7_4_0_1_0, 36'h9_0_4_6_6_3_0_1_3,
    36'h9_1_0_6_5_0_0_0_0, 36'ha_1_0_6_5_0_0_1_0, 36'ha_1_0_6_6_0_0_0_0,
    36'hb_1_0_5_5_8_0_1_8, 36'hb_1_0_4_5_0_0_0_0, 36'hc_1_0_4_5_0_0_1_0,
    36'hd_0_6_0_0_2_b_4_0, 36'hd_0_5_0_0_d_2_4_f, 36'h0_0_8_8_0_4_0_0_6,
    36'h0_0_1_1_0_5_0_0_4, 36'h0_0_0_0_0_5_0_0_5, 36'h0_0_7_5_0_8_2_4_a,
    36'h0_1_0_9_1_8_0_2_b, 36'h0_0_4_4_0_8_8_4_8, 36'h2_0_3_5_0_8_8_4_a,
    36'h2_1_0_9_3_8_6_2_8, 36'h6_0_9_3_0_8_a_4_8, 36'he_0_1_1_1_3_0_0_3};

  // free running 100 mhz clock
  always #5 clk = ~clk;

  nalu_core uut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_req(op_req),
    .res_reg(res_reg), .res_valid_reg(res_valid_reg), .flags_reg(flags_reg),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .bus_rdata_reg(bus_rdata_reg));

  nalu_mem_model u_mem (.clk(clk), .sys_rst(sys_rst), .res(res_reg),
    .gen_nib_reg(gen_nib), .mem_nib_reg(mem_nib));

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk);
    bus_write <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    @(posedge clk);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_read <= 1'b0;
    #1;
    chk(bus_rdata_reg, e);
  endtask

  task automatic issue(input logic [35:0] x);
    @(posedge clk);
    op_valid <= 1'b1;
    op_req <= {x[35:32], x[28], x[27:16]};
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task results;
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // reset values, read-only place, unmapped place
    rd(8'h7e, 4'h0);
    rd(8'h7f, 4'h0);
    wr(8'h7d, 4'h5);
    rd(8'h7d, 4'h0);
    wr(8'h10, 4'hf);
    rd(8'h10, 4'h0);
    wr(8'h7f, 4'h7);
    wr(8'h7e, 4'h1);
    rd(8'h7f, 4'h7);
    chk(flags_reg, 4'hf);
    // ordinary operations from the table
    foreach (rows[i])
    begin
      r = rows[i];
      wr(8'h7e, {3'h0, r[15]});
      wr(8'h7f, {1'b0, r[14:12]});
      issue(r);
      chk({3'h0, res_valid_reg}, 4'h1);
      chk({1'b0, res_reg[2:0]}, r[7:4]);
      if (r[6:5] != 2'b00)
        chk(res_reg.data, r[11:8]);
      chk(flags_reg, r[3:0]);
      @(posedge clk);
      #1;
      chk({3'h0, res_valid_reg}, 4'h0);
      chk(res_reg.data, 4'h0);
      if (r[6])
        chk(gen_nib, r[11:8]);
      if (r[5])
        chk(mem_nib, r[11:8]);
    end
    // back to back, carry of the first feeds the second
    wr(8'h7e, 4'h0);
    wr(8'h7f, 4'h0);
    @(posedge clk);
    op_valid <= 1'b1;
    op_req <= {4'h0, 1'b0, 4'hf, 4'h1, 4'h0};
    @(posedge clk);
    op_req <= {4'h1, 1'b0, 4'h2, 4'h3, 4'h0};
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
    chk(res_reg.data, 4'h6);
    chk(flags_reg, 4'h0);
    rd(8'h7d, 4'h6);
    // second reset in mid run clears every flag
    wr(8'h7f, 4'h7);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(flags_reg, 4'h0);
    @(posedge clk);
    sys_rst <= 1'b0;
    // after the second release: flags and last result cleared, ops answer again
    rd(8'h7f, 4'h0);
    rd(8'h7d, 4'h0);
    issue(36'h0_0_1_2_0_0_3_4_0);
    chk({3'h0, res_valid_reg}, 4'h1);
    chk(res_reg.data, 4'h3);
    results();
  end
endmodule
`default_nettype wire
